// file: rtl/mcpt_cfg.svh
`ifndef MCPT_CFG_SVH
`define MCPT_CFG_SVH

// Register indices; byte address is four times the index
`define MCPT_IDX_MODE_CTRL 8'hA1
`define MCPT_IDX_FLAG_CTRL 8'hA9
`define MCPT_IDX_CNT_LO 8'hAA
`define MCPT_IDX_CNT_HI 8'hAB
`define MCPT_IDX_DUTY_LO 8'hAC
`define MCPT_IDX_DUTY_HI 8'hAD
`define MCPT_IDX_PER_LO 8'hAE
`define MCPT_IDX_PER_HI 8'hAF
`define MCPT_ADDR_W 10

// Mode control fields
`define MCPT_PSC_HI 7
`define MCPT_PSC_LO 5
`define MCPT_OCM_BIT 4
`define MCPT_IRE_BIT 3
`define MCPT_CES_BIT 2
`define MCPT_MODE_HI 1
`define MCPT_MODE_LO 0

// Flag and enable control fields
`define MCPT_MW_FLAG_BIT 7
`define MCPT_CYC_FLAG_BIT 6
`define MCPT_OVF_FLAG_BIT 5
`define MCPT_CYC_IE_BIT 4
`define MCPT_OVF_IE_BIT 3
`define MCPT_FILT_BIT 2
`define MCPT_DIR_BIT 1
`define MCPT_CEN_BIT 0

// Values and timing
`define MCPT_RESET_BYTE 8'h00
`define MCPT_RESET_WORD 16'h0000
`define MCPT_CNT_MAX 16'hFFFF
`define MCPT_CNT_ONE 16'h0001
`define MCPT_FILT_LEN 4
`define MCPT_PSC_W 7

`endif

// file: rtl/mcpt_pkg.sv
package mcpt_pkg;
    typedef enum logic [1:0] {
        MCPT_CAPTURE,
        MCPT_OUTPUT,
        MCPT_COUNT,
        MCPT_ROTATE
    } mcpt_mode_e;
endpackage : mcpt_pkg

// file: rtl/mcpt_input_filter.sv
`include "mcpt_cfg.svh"

module mcpt_input_filter #(
    parameter int WIDTH = 4,
    parameter int FILT_LEN = `MCPT_FILT_LEN
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Control
    input wire logic filtEn,
    // Pins and filtered levels
    input wire logic [WIDTH-1:0] rawIn,
    output logic [WIDTH-1:0] filtOut,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    localparam int CW = $clog2(FILT_LEN) + 1;
    localparam logic [CW-1:0] LAST = CW'(FILT_LEN - 1);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gChan
            logic meta_r, sync_r, filt_r, prev_r;
            logic filt_nxt;
            logic [CW-1:0] run_r, run_nxt;

            // Level must hold four cycles before it is believed
            always_comb begin
                filt_nxt = filt_r;
                run_nxt = '0;
                if (!filtEn) begin
                    filt_nxt = sync_r;
                end else if (sync_r != filt_r) begin
                    if (run_r == LAST) begin
                        filt_nxt = sync_r;
                    end else begin
                        run_nxt = run_r + CW'(1);
                    end
                end
            end

            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                    filt_r <= 1'b0;
                    prev_r <= 1'b0;
                    run_r <= '0;
                end else begin
                    meta_r <= rawIn[g];
                    sync_r <= meta_r;
                    filt_r <= filt_nxt;
                    prev_r <= filt_r;
                    run_r <= run_nxt;
                end
            end

            assign filtOut[g] = filt_r;
            assign rise[g] = filt_r & ~prev_r;
            assign fall[g] = ~filt_r & prev_r;
        end
    endgenerate
endmodule : mcpt_input_filter

// file: rtl/mcpt_quad_decoder.sv
module mcpt_quad_decoder (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Filtered phases
    input wire logic phA,
    input wire logic phB,
    // Decoded step
    output logic step,
    output logic backward
);
    logic prevA_r, prevB_r, step_r, back_r;
    logic step_nxt, back_nxt;

    // A leading B counts forward; double changes are dropped as glitches
    always_comb begin
        step_nxt = (phA ^ prevA_r) ^ (phB ^ prevB_r);
        back_nxt = back_r;
        if (step_nxt) begin
            back_nxt = ~(phA ^ prevB_r);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prevA_r <= 1'b0;
            prevB_r <= 1'b0;
            step_r <= 1'b0;
            back_r <= 1'b0;
        end else begin
            prevA_r <= phA;
            prevB_r <= phB;
            step_r <= step_nxt;
            back_r <= back_nxt;
        end
    end

    assign step = step_r;
    assign backward = back_r;
endmodule : mcpt_quad_decoder

// file: rtl/mcpt_timer.sv
`include "mcpt_cfg.svh"

// Contract
// - Prescaler code n in mode control bits 7:5 divides clock by two to n.
// - Output low while count at or below duty; polarity bit inverts.
// - Mode bits pick capture, PWM output, pulse counting or rotation.
// - Mode bit 3 gates match, width or direction-change interrupt; not counting.
// - Capture: edge select picks rising or falling reference, width high or low.
// - Counting: edge select 0 counts falling edges, 1 rising edges.
// - Rotation: edge select 1 lets zero point clear the pulse counter.
// - Output: bit 7 flag set when count equals duty.
// - Capture: bit 7 flag set when pulse width measured.
// - Capture: bit 6 flag set when full input cycle detected.
// - Counting: bit 6 flag set when pulse total reaches duty.
// - Rotation: bit 6 flag set on each decoded active edge.
// - Capture: count at 0xFFFF sets overflow flag and clears count.
// - Counting: count at 0xFFFF sets overflow flag and clears count.
// - Rotation: base timer at 0xFFFF sets overflow flag and clears it.
// - Flag register bit 4 gates bit 6 interrupt except in output mode.
// - Flag register bit 3 gates overflow interrupt in every mode.
// - Filter enable drops input pulses shorter than four clocks.
// - Read-only direction bit: 0 forward, 1 backward.
// - Count register shows pulse counter in rotation, base timer otherwise.
// - Duty holds captured width, pulse total, or pulse counter at zero point.
// - Period is PWM period, or base count stored on cycle, match, step.
// - High byte first; no shadow transfer between high and low writes.
module mcpt_timer #(
    parameter int PSC_W = `MCPT_PSC_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [`MCPT_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Timer pins
    input wire logic capIn,
    input wire logic phaseA,
    input wire logic phaseB,
    input wire logic zeroPoint,
    output logic pwmOut,
    output logic timerIrq
);
    function automatic logic regHit(input logic [`MCPT_ADDR_W-1:0] a, input logic [7:0] idx);
        return (a[`MCPT_ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
    endfunction : regHit

    function automatic logic [PSC_W-1:0] pscMask(input logic [2:0] code);
        return PSC_W'((1 << code) - 1);
    endfunction : pscMask

    // Register state
    logic [7:0] cr0_r, cr0_nxt;
    logic cycIe_r, cycIe_nxt, ovfIe_r, ovfIe_nxt, filtEn_r, filtEn_nxt, cen_r, cen_nxt;
    logic mwFlag_r, mwFlag_nxt, cycFlag_r, cycFlag_nxt, ovfFlag_r, ovfFlag_nxt;
    logic dir_r;
    logic [15:0] cnt_r, cnt_nxt, pulse_r, pulse_nxt;
    logic [15:0] duty_r, duty_nxt, period_r, period_nxt;
    logic [15:0] dutySh_r, dutySh_nxt, perSh_r, perSh_nxt;
    logic pendDuty_r, pendDuty_nxt, pendPer_r, pendPer_nxt;
    logic armed_r, armed_nxt, pwm_r, pwm_nxt, irq_r, irq_nxt;
    logic [PSC_W-1:0] psc_r, psc_nxt;
    // Bus state
    logic wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // Event decode
    mcpt_pkg::mcpt_mode_e mode;
    logic [3:0] fLvl, fRise, fFall;
    logic qStep, qBack, tick, ces, actEdge, othEdge, zeroClr;
    logic swWr, wrCr1, wrCnt;
    logic [7:0] wd;
    logic mwSet, cycSet, ovfEv, dutyLoad, perLoad;

    mcpt_input_filter #(.WIDTH(4), .FILT_LEN(`MCPT_FILT_LEN)) uFilter (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .filtEn(filtEn_r),
        .rawIn({zeroPoint, phaseB, phaseA, capIn}),
        .filtOut(fLvl),
        .rise(fRise),
        .fall(fFall)
    );

    mcpt_quad_decoder uQuad (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .phA(fLvl[1]),
        .phB(fLvl[2]),
        .step(qStep),
        .backward(qBack)
    );

    assign mode = mcpt_pkg::mcpt_mode_e'(cr0_r[`MCPT_MODE_HI:`MCPT_MODE_LO]);
    assign ces = cr0_r[`MCPT_CES_BIT];
    // Capture references one edge, counting the other sense
    assign actEdge = (mode == mcpt_pkg::MCPT_COUNT) ? (ces ? fRise[0] : fFall[0])
                                                    : (ces ? fFall[0] : fRise[0]);
    assign othEdge = ces ? fRise[0] : fFall[0];
    assign zeroClr = ces && fRise[3];
    // Prescaler is unbuffered: change it only while the timer is stopped
    assign tick = cen_r && ((psc_r & pscMask(cr0_r[`MCPT_PSC_HI:`MCPT_PSC_LO]))
                            == pscMask(cr0_r[`MCPT_PSC_HI:`MCPT_PSC_LO]));
    assign swWr = avs_write && !wait_r && avs_byteenable[0];
    assign wd = avs_writedata[7:0];
    assign wrCr1 = swWr && regHit(avs_address, `MCPT_IDX_FLAG_CTRL);
    assign wrCnt = swWr && (regHit(avs_address, `MCPT_IDX_CNT_LO)
                            || regHit(avs_address, `MCPT_IDX_CNT_HI));

    always_comb begin
        cr0_nxt = cr0_r;
        cycIe_nxt = cycIe_r;
        ovfIe_nxt = ovfIe_r;
        filtEn_nxt = filtEn_r;
        cen_nxt = cen_r;
        mwFlag_nxt = mwFlag_r;
        cycFlag_nxt = cycFlag_r;
        ovfFlag_nxt = ovfFlag_r;
        cnt_nxt = cnt_r;
        pulse_nxt = pulse_r;
        duty_nxt = duty_r;
        period_nxt = period_r;
        pendDuty_nxt = pendDuty_r;
        pendPer_nxt = pendPer_r;
        armed_nxt = armed_r;
        pwm_nxt = 1'b0;
        psc_nxt = cen_r ? psc_r + PSC_W'(1) : '0;
        mwSet = 1'b0;
        cycSet = 1'b0;
        ovfEv = 1'b0;
        dutyLoad = !cen_r;
        perLoad = !cen_r;
        // Software side first so that hardware events win the same cycle
        if (swWr && regHit(avs_address, `MCPT_IDX_MODE_CTRL)) begin
            cr0_nxt = wd;
        end
        if (wrCr1) begin
            cycIe_nxt = wd[`MCPT_CYC_IE_BIT];
            ovfIe_nxt = wd[`MCPT_OVF_IE_BIT];
            filtEn_nxt = wd[`MCPT_FILT_BIT];
            cen_nxt = wd[`MCPT_CEN_BIT];
            mwFlag_nxt = mwFlag_r & wd[`MCPT_MW_FLAG_BIT];
            cycFlag_nxt = cycFlag_r & wd[`MCPT_CYC_FLAG_BIT];
            ovfFlag_nxt = ovfFlag_r & wd[`MCPT_OVF_FLAG_BIT];
        end
        if (swWr && regHit(avs_address, `MCPT_IDX_CNT_LO)) begin
            if (mode == mcpt_pkg::MCPT_ROTATE) begin
                pulse_nxt[7:0] = wd;
            end else begin
                cnt_nxt[7:0] = wd;
            end
        end
        if (swWr && regHit(avs_address, `MCPT_IDX_CNT_HI)) begin
            if (mode == mcpt_pkg::MCPT_ROTATE) begin
                pulse_nxt[15:8] = wd;
            end else begin
                cnt_nxt[15:8] = wd;
            end
        end
        // High byte arms a pending pair, low byte completes it
        if (swWr && regHit(avs_address, `MCPT_IDX_DUTY_HI)) begin
            duty_nxt[15:8] = wd;
            pendDuty_nxt = 1'b1;
        end
        if (swWr && regHit(avs_address, `MCPT_IDX_DUTY_LO)) begin
            duty_nxt[7:0] = wd;
            pendDuty_nxt = 1'b0;
        end
        if (swWr && regHit(avs_address, `MCPT_IDX_PER_HI)) begin
            period_nxt[15:8] = wd;
            pendPer_nxt = 1'b1;
        end
        if (swWr && regHit(avs_address, `MCPT_IDX_PER_LO)) begin
            period_nxt[7:0] = wd;
            pendPer_nxt = 1'b0;
        end
        // Base timer
        if (tick) begin
            if (mode == mcpt_pkg::MCPT_OUTPUT) begin
                if (cnt_r == perSh_r) begin
                    cnt_nxt = '0;
                    ovfEv = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + `MCPT_CNT_ONE;
                end
                mwSet = (cnt_r == dutySh_r);
            end else if (cnt_r == `MCPT_CNT_MAX) begin
                cnt_nxt = '0;
                ovfEv = 1'b1;
            end else begin
                cnt_nxt = cnt_r + `MCPT_CNT_ONE;
            end
        end
        if (!cen_r) begin
            armed_nxt = 1'b0;
        end
        unique case (mode)
            mcpt_pkg::MCPT_OUTPUT: begin
                pwm_nxt = cr0_r[`MCPT_OCM_BIT] ^ (cnt_r > dutySh_r);
                dutyLoad = dutyLoad || ovfEv;
                perLoad = perLoad || ovfEv;
            end
            mcpt_pkg::MCPT_CAPTURE: begin
                if (cen_r && !armed_r && actEdge) begin
                    cnt_nxt = '0;
                    armed_nxt = 1'b1;
                end else if (cen_r && armed_r) begin
                    if (othEdge) begin
                        duty_nxt = cnt_r;
                        mwSet = 1'b1;
                    end
                    if (actEdge) begin
                        period_nxt = cnt_r;
                        cnt_nxt = '0;
                        cycSet = 1'b1;
                    end
                end
            end
            mcpt_pkg::MCPT_COUNT: begin
                dutyLoad = dutyLoad || ovfEv;
                if (cen_r && !armed_r && actEdge) begin
                    cnt_nxt = '0;
                    armed_nxt = 1'b1;
                end else if (cen_r && armed_r && actEdge) begin
                    if (pulse_r + `MCPT_CNT_ONE == dutySh_r) begin
                        period_nxt = cnt_r;
                        cnt_nxt = '0;
                        pulse_nxt = '0;
                        cycSet = 1'b1;
                        dutyLoad = 1'b1;
                    end else begin
                        pulse_nxt = pulse_r + `MCPT_CNT_ONE;
                    end
                end
            end
            mcpt_pkg::MCPT_ROTATE: begin
                mwSet = cen_r && (qBack != dir_r);
                if (cen_r && qStep) begin
                    pulse_nxt = qBack ? pulse_r - `MCPT_CNT_ONE : pulse_r + `MCPT_CNT_ONE;
                    period_nxt = cnt_r;
                    cnt_nxt = '0;
                    cycSet = 1'b1;
                end
                if (cen_r && zeroClr) begin
                    duty_nxt = pulse_r;
                    pulse_nxt = '0;
                end
            end
        endcase
        // Set beats a clear written in the same cycle
        mwFlag_nxt = mwFlag_nxt | mwSet;
        cycFlag_nxt = cycFlag_nxt | cycSet;
        ovfFlag_nxt = ovfFlag_nxt | ovfEv;
        // Shadow copies stay put while a high byte waits for its low byte
        dutySh_nxt = (dutyLoad && !pendDuty_r && !pendDuty_nxt) ? duty_r : dutySh_r;
        perSh_nxt = (perLoad && !pendPer_r && !pendPer_nxt) ? period_r : perSh_r;
        irq_nxt = (mwFlag_r && cr0_r[`MCPT_IRE_BIT] && mode != mcpt_pkg::MCPT_COUNT)
                  || (cycFlag_r && cycIe_r && mode != mcpt_pkg::MCPT_OUTPUT)
                  || (ovfFlag_r && ovfIe_r);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cr0_r <= `MCPT_RESET_BYTE;
            cycIe_r <= 1'b0;
            ovfIe_r <= 1'b0;
            filtEn_r <= 1'b0;
            cen_r <= 1'b0;
            mwFlag_r <= 1'b0;
            cycFlag_r <= 1'b0;
            ovfFlag_r <= 1'b0;
            dir_r <= 1'b0;
            cnt_r <= `MCPT_RESET_WORD;
            pulse_r <= `MCPT_RESET_WORD;
            duty_r <= `MCPT_RESET_WORD;
            period_r <= `MCPT_RESET_WORD;
            dutySh_r <= `MCPT_RESET_WORD;
            perSh_r <= `MCPT_RESET_WORD;
            pendDuty_r <= 1'b0;
            pendPer_r <= 1'b0;
            armed_r <= 1'b0;
            pwm_r <= 1'b0;
            irq_r <= 1'b0;
            psc_r <= '0;
        end else begin
            cr0_r <= cr0_nxt;
            cycIe_r <= cycIe_nxt;
            ovfIe_r <= ovfIe_nxt;
            filtEn_r <= filtEn_nxt;
            cen_r <= cen_nxt;
            mwFlag_r <= mwFlag_nxt;
            cycFlag_r <= cycFlag_nxt;
            ovfFlag_r <= ovfFlag_nxt;
            dir_r <= qBack;
            cnt_r <= cnt_nxt;
            pulse_r <= pulse_nxt;
            duty_r <= duty_nxt;
            period_r <= period_nxt;
            dutySh_r <= dutySh_nxt;
            perSh_r <= perSh_nxt;
            pendDuty_r <= pendDuty_nxt;
            pendPer_r <= pendPer_nxt;
            armed_r <= armed_nxt;
            pwm_r <= pwm_nxt;
            irq_r <= irq_nxt;
            psc_r <= psc_nxt;
        end
    end

    // Bus slave: one wait cycle, data latched while waitrequest is high
    always_comb begin
        wait_nxt = !((avs_read || avs_write) && wait_r);
        rdata_nxt = rdata_r;
        if (avs_read && wait_r) begin
            rdata_nxt = '0;
            if (regHit(avs_address, `MCPT_IDX_MODE_CTRL)) begin
                rdata_nxt[7:0] = cr0_r;
            end else if (regHit(avs_address, `MCPT_IDX_FLAG_CTRL)) begin
                rdata_nxt[7:0] = {mwFlag_r, cycFlag_r, ovfFlag_r, cycIe_r, ovfIe_r,
                                  filtEn_r, dir_r, cen_r};
            end else if (regHit(avs_address, `MCPT_IDX_CNT_LO)) begin
                rdata_nxt[7:0] = (mode == mcpt_pkg::MCPT_ROTATE) ? pulse_r[7:0] : cnt_r[7:0];
            end else if (regHit(avs_address, `MCPT_IDX_CNT_HI)) begin
                rdata_nxt[7:0] = (mode == mcpt_pkg::MCPT_ROTATE) ? pulse_r[15:8] : cnt_r[15:8];
            end else if (regHit(avs_address, `MCPT_IDX_DUTY_LO)) begin
                rdata_nxt[7:0] = duty_r[7:0];
            end else if (regHit(avs_address, `MCPT_IDX_DUTY_HI)) begin
                rdata_nxt[7:0] = duty_r[15:8];
            end else if (regHit(avs_address, `MCPT_IDX_PER_LO)) begin
                rdata_nxt[7:0] = period_r[7:0];
            end else if (regHit(avs_address, `MCPT_IDX_PER_HI)) begin
                rdata_nxt[7:0] = period_r[15:8];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wait_r <= 1'b1;
            rdata_r <= '0;
        end else begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign pwmOut = pwm_r;
    assign timerIrq = irq_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_bus_answer_one: assert property ((avs_read || avs_write) && avs_waitrequest
                                       |=> !avs_waitrequest)
        else $error("bus request not answered after one wait cycle");
    a_ovf_clears_count: assert property (mode != mcpt_pkg::MCPT_OUTPUT && tick
                                         && cnt_r == `MCPT_CNT_MAX |=> ovfFlag_r && cnt_r == '0)
        else $error("overflow at full count not flagged or count not cleared");
    a_match_sets_flag: assert property (mode == mcpt_pkg::MCPT_OUTPUT && tick
                                        && cnt_r == dutySh_r |=> mwFlag_r)
        else $error("compare match did not set the match flag");
    a_pwm_level_ok: assert property (mode == mcpt_pkg::MCPT_OUTPUT
        |=> pwmOut == ($past(cr0_r[`MCPT_OCM_BIT]) ^ ($past(cnt_r) > $past(dutySh_r))))
        else $error("PWM level does not follow count against duty");
    a_flag_write_one: assert property (wrCr1 && wd[`MCPT_MW_FLAG_BIT] && mwFlag_r
                                       |=> mwFlag_r)
        else $error("writing one changed a set flag");
    a_capture_width: assert property (mode == mcpt_pkg::MCPT_CAPTURE && cen_r
                                      && armed_r && othEdge |=> mwFlag_r && duty_r == $past(cnt_r))
        else $error("pulse width not captured into duty");
    a_capture_cycle: assert property (mode == mcpt_pkg::MCPT_CAPTURE && cen_r
        && armed_r && actEdge |=> cycFlag_r && period_r == $past(cnt_r) && cnt_r == '0)
        else $error("input cycle not captured into period");
    a_count_match: assert property (mode == mcpt_pkg::MCPT_COUNT && cen_r && armed_r
        && actEdge && pulse_r + `MCPT_CNT_ONE == dutySh_r |=> cycFlag_r && pulse_r == '0)
        else $error("pulse total match not flagged");
    a_rotate_step_up: assert property (mode == mcpt_pkg::MCPT_ROTATE && cen_r && qStep
        && !qBack && !zeroClr && !wrCnt |=> pulse_r == $past(pulse_r) + `MCPT_CNT_ONE)
        else $error("forward step did not advance pulse counter");
    a_shadow_held: assert property (pendDuty_r |=> $stable(dutySh_r))
        else $error("duty shadow changed between high and low byte writes");

    c_output_wrap: cover property (mode == mcpt_pkg::MCPT_OUTPUT && ovfEv ##1 ovfFlag_r);
    c_capture_cycle: cover property (mode == mcpt_pkg::MCPT_CAPTURE && cycSet);
    c_count_match: cover property (mode == mcpt_pkg::MCPT_COUNT && cycSet);
    c_rotate_reverse: cover property (mode == mcpt_pkg::MCPT_ROTATE && qStep && qBack);
endmodule : mcpt_timer

// file: verification/mcpt_pwm_source.sv
module mcpt_pwm_source #(
    parameter int HALF = 10
) (
    // Clock and pacing
    input wire logic sys_clk,
    input wire logic run,
    input wire logic rev,
    // Driven lines
    output logic sig,
    output logic quadA,
    output logic quadB
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    logic [HALF/2-1:0] lag = '0;
    // Second phase trails by a quarter period; rev swaps which one leads
    assign quadA = rev ? lag[HALF/2-1] : sig;
    assign quadB = rev ? sig : lag[HALF/2-1];
    // Low while stopped, so no stale edge reaches the timer
    always @(posedge sys_clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        lag <= {lag[HALF/2-2:0], sig};
        if (!run) begin
            sig <= 1'b0;
        end else if (cnt == HALF - 1) begin
            sig <= ~sig;
        end
    end
endmodule : mcpt_pwm_source

// file: verification/tb_mcpt_timer.sv
module tb_mcpt_timer;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [9:0] avsAddress = 10'h000;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h00000000;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic capIn;
    logic srcRun = 1'b0;
    logic quadRev = 1'b0;
    logic zeroPt = 1'b0;
    logic phA;
    logic phB;
    logic pwmOut;
    logic timerIrq;
    logic [31:0] expQ[$];
    logic [7:0] regIdx[9] = '{8'hA1, 8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hAF, 8'hA0};
    logic [7:0] ctl[3] = '{8'h00, 8'h04, 8'h0A};
    logic [7:0] flg[3] = '{8'hC1, 8'hC1, 8'h41};
    logic [31:0] rnd;
    int errors = 0;
    int checks = 0;
    int highs;
    mcpt_timer mcpt_timer_i (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
        .avs_byteenable(4'hF), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
        .capIn(capIn), .phaseA(phA), .phaseB(phB), .zeroPoint(zeroPt), .pwmOut(pwmOut),
        .timerIrq(timerIrq));
    mcpt_pwm_source mcpt_pwm_source_i (.sys_clk(sys_clk), .run(srcRun), .rev(quadRev),
        .sig(capIn), .quadA(phA), .quadB(phB));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        avsAddress <= {idx, 2'b00};
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= {24'h000000, d};
        // Only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge sys_clk);
        end while (avsWaitrequest !== 1'b0);
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        expQ.push_back({24'h000000, e});
        bus(1'b0, idx, 8'h00);
    endtask : rd
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // Read data is judged only at the accepting edge
    always @(posedge sys_clk) begin
        if (avsRead === 1'b1 && avsWaitrequest === 1'b0 && expQ.size() > 0) begin
            chk(avsReaddata, expQ.pop_front());
        end
    end
    initial forever #5 sys_clk = ~sys_clk;
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end
    initial begin
        rnd = $urandom(66);
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        foreach (regIdx[i]) rd(regIdx[i], 8'h00);
        rnd = $urandom();
        bus(1'b1, 8'hAD, rnd[15:8]);
        bus(1'b1, 8'hAC, rnd[7:0]);
        bus(1'b1, 8'hA1, rnd[23:16]);
        rd(8'hAD, rnd[15:8]);
        rd(8'hAC, rnd[7:0]);
        rd(8'hA1, rnd[23:16]);
        bus(1'b1, 8'hAF, 8'h00);
        bus(1'b1, 8'hAE, 8'h05);
        bus(1'b1, 8'hAD, 8'h00);
        bus(1'b1, 8'hAC, 8'h01);
        for (int pol = 0; pol < 2; pol++) begin
            bus(1'b1, 8'hA9, 8'h00);
            bus(1'b1, 8'hA1, pol[0] ? 8'h11 : 8'h01);
            bus(1'b1, 8'hA9, 8'h01);
            repeat (20) @(posedge sys_clk);
            highs = 0;
            repeat (60) begin
                @(posedge sys_clk);
                highs += (pwmOut === 1'b1);
            end
            chk(highs, pol ? 20 : 40);
        end
        rd(8'hA9, 8'hA1);
        // Stop with ones written back: flags must survive
        bus(1'b1, 8'hA9, 8'hA8);
        rd(8'hA9, 8'hA8);
        repeat (3) @(posedge sys_clk);
        chk(timerIrq, 1'b1);
        bus(1'b1, 8'hA9, 8'h08);
        rd(8'hA9, 8'h08);
        repeat (3) @(posedge sys_clk);
        chk(timerIrq, 1'b0);
        srcRun <= 1'b1;
        foreach (ctl[i]) begin
            bus(1'b1, 8'hA9, 8'h00);
            // Second clear runs stopped, so no late event refills a flag
            bus(1'b1, 8'hA9, 8'h00);
            bus(1'b1, 8'hAD, 8'h00);
            bus(1'b1, 8'hAC, 8'h03);
            bus(1'b1, 8'hA1, ctl[i]);
            bus(1'b1, 8'hA9, 8'h01);
            repeat (200) @(posedge sys_clk);
            rd(8'hA9, flg[i]);
        end
        // Counting mode with no input: preset near the top and let it wrap
        srcRun <= 1'b0;
        bus(1'b1, 8'hA9, 8'h00);
        bus(1'b1, 8'hA9, 8'h00);
        bus(1'b1, 8'hAB, 8'hFF);
        bus(1'b1, 8'hAA, 8'hF0);
        bus(1'b1, 8'hA9, 8'h09);
        repeat (40) @(posedge sys_clk);
        rd(8'hA9, 8'h29);
        chk(timerIrq, 1'b1);
        // Rotation: a step every five clocks, then reversed phases, then zero point
        bus(1'b1, 8'hA9, 8'h00);
        bus(1'b1, 8'hA9, 8'h00);
        bus(1'b1, 8'hA1, 8'h07);
        srcRun <= 1'b1;
        bus(1'b1, 8'hA9, 8'h01);
        repeat (200) @(posedge sys_clk);
        rd(8'hAE, 8'h04);
        rd(8'hAF, 8'h00);
        rd(8'hA9, 8'h41);
        quadRev <= 1'b1;
        repeat (100) @(posedge sys_clk);
        rd(8'hA9, 8'hC3);
        srcRun <= 1'b0;
        repeat (30) @(posedge sys_clk);
        zeroPt <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rd(8'hAA, 8'h00);
        rd(8'hAB, 8'h00);
        tally_and_finish();
    end
endmodule : tb_mcpt_timer
